/* File: inc/fsam_consts.svh */
// Constants for the flash space access mapper
`ifndef FSAM_CONSTS_SVH
`define FSAM_CONSTS_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define FSAM_USER_AW        14
`define FSAM_USER_PAGES     128
`define FSAM_PAGE_AW        7
`define FSAM_PAGE_BYTES     128
`define FSAM_EE_AW          11
`define FSAM_BOOT_AW        11
`define FSAM_TMR_W          16

// ----------------------------------------------------------------
// Register offsets and bit positions
// ----------------------------------------------------------------
`define FSAM_OFS_FMAP       12'h000
`define FSAM_OFS_EEMAP      12'h004
`define FSAM_OFS_STATUS     12'h008
`define FSAM_OFS_SEC        12'h00C
`define FSAM_EE_MAP_BIT     1
`define FSAM_ST_FBUSY       0
`define FSAM_ST_EBUSY       1
`define FSAM_ST_HOLD        2
`define FSAM_ST_REFUSED     3

// ----------------------------------------------------------------
// Mapping codes, commands, windows, reset values
// ----------------------------------------------------------------
`define FSAM_MAP_NONE       4'h0
`define FSAM_MAP_EXTRA_ROW_SPACE       4'h2
`define FSAM_MAP_SEC        4'h4
`define FSAM_MAP_BOOT       4'h8
`define FSAM_CMD_ARM        4'h5
`define FSAM_CMD_GO         4'hA
`define FSAM_EXTRA_ROW_SPACE_BASE      9'h1FF
`define FSAM_SEC_ADDR       16'h0000
`define FSAM_SEC_RESET      8'hFF
`define FSAM_ERASED         8'hFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FSAM_CLK_PERIOD_NS  20
`define FSAM_PROG_TIME_NS   5000
`define FSAM_PROG_CYCLES    ((`FSAM_PROG_TIME_NS + `FSAM_CLK_PERIOD_NS - 1) / `FSAM_CLK_PERIOD_NS)

`endif

/* File: inc/fsam_pkg.sv */
// Types shared by the flash space access mapper
`default_nettype none
`include "fsam_consts.svh"

package fsam_pkg;

    // Core access kinds
    typedef enum logic [1:0] {OP_CODE_RD, OP_BOOT_RD, OP_DATA_RD, OP_DATA_WR} fsam_op_t;

    // Write sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_COPY} fsam_wst_t;

    // Registered state of the mapper, apart from arrays, latches and synchroniser
    typedef struct packed {
        logic [7:0]                              fmap;
        logic [7:0]                              eemap;
        logic                                    f_armed;
        logic                                    e_armed;
        logic [3:0]                              f_tgt;
        logic [`FSAM_USER_AW-`FSAM_PAGE_AW-1:0]  f_page;
        logic [`FSAM_EE_AW-`FSAM_PAGE_AW-1:0]    e_page;
        fsam_wst_t                               wst;
        logic                                    wr_is_ee;
        logic [3:0]                              wr_tgt;
        logic                                    wr_par;
        logic                                    wr_hold;
        logic [`FSAM_TMR_W-1:0]                  tmr;
        logic [`FSAM_PAGE_AW-1:0]                idx;
        logic                                    refused;
        logic [7:0]                              sec;
        logic                                    apb_done;
        logic [31:0]                             prdata;
        logic                                    pslverr;
        logic                                    ack;
        logic [7:0]                              rdata;
        logic                                    denied;
    } fsam_state_t;

endpackage
`default_nettype wire

/* File: hw/fsam_bit_sync.sv */
// Two-stage synchroniser for one asynchronous level
`default_nettype none

module fsam_bit_sync
(
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output logic      o_sync
);
    typedef struct packed {
        logic meta;
        logic sync;
    } fsam_sync_t;

    fsam_sync_t q;
    fsam_sync_t d;

    // First stage feeds only the second
    always_comb
    begin
        d.meta = i_async;
        d.sync = q.meta;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            q <= '0;
        else
            q <= d;
    end

    assign o_sync = q.sync;
endmodule // fsam_bit_sync
`default_nettype wire

/* File: hw/fsam_page_latch.sv */
// Page-wide column latch with per-byte loaded flags
`default_nettype none
`include "fsam_consts.svh"

module fsam_page_latch
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = `FSAM_PAGE_BYTES
)
(
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_load,
    input  wire logic [$clog2(DEPTH)-1:0] i_load_idx,
    input  wire logic [WIDTH-1:0]         i_load_data,
    input  wire logic                     i_clear,
    input  wire logic [$clog2(DEPTH)-1:0] i_rd_idx,
    output logic      [WIDTH-1:0]         o_rd_data,
    output logic                          o_rd_valid
);
    typedef struct packed {
        logic [DEPTH-1:0] loaded;
    } fsam_latch_t;

    fsam_latch_t q;
    fsam_latch_t d;
    logic [WIDTH-1:0] mem [DEPTH];

    // Clear beats a load; loads are blocked while a page is written anyway
    always_comb
    begin
        d = q;
        if (i_clear)
            d.loaded = '0;
        else if (i_load)
            d.loaded[i_load_idx] = 1'b1;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            q <= '0;
        else
            q <= d;
    end

    // Byte storage needs no reset: the loaded flags qualify it
    always_ff @(posedge i_ref_clk)
    begin
        if (i_load)
            mem[i_load_idx] <= i_load_data;
    end

    assign o_rd_data  = mem[i_rd_idx];
    assign o_rd_valid = q.loaded[i_rd_idx];
endmodule // fsam_page_latch
`default_nettype wire

/* File: hw/fsam_top.sv */
// Flash space access mapper: space decode, latch loads and page writes
//
// Behaviour
// - User flash is 16K bytes as 128 pages of 128 bytes.
// - A 128-byte extra row sits beside the user array.
// - Security byte: upper nibble software written, lower only in parallel mode.
// - 128-byte column latches buffer every user, extra row, security write.
// - User array writes launched by user flash code are refused outside parallel mode.
// - Boot flash is written only in parallel programming mode.
// - User code reads and loads latches; boot code also writes user flash.
// - Code reads return user bytes at the given address; map idle is zero.
// - Map value 02h exposes extra row at FF80h to FFFFh.
// - Map value 04h exposes security byte at 0000h.
// - Boot code reads all spaces and writes all but boot flash while still executing.
// - User code writing the extra row idles outside parallel mode; EEPROM writes read-while-write.
// - EEPROM control 02h maps EEPROM for data reads and latch loads.
//
// Chosen here: the address map and register access over APB.
`default_nettype none
`include "fsam_consts.svh"

module fsam_top
#(
    parameter logic [`FSAM_TMR_W-1:0] PROG_CYCLES = `FSAM_TMR_W'(`FSAM_PROG_CYCLES)
)
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_psel,
    input  wire logic             i_penable,
    input  wire logic             i_pwrite,
    input  wire logic [11:0]      i_paddr,
    input  wire logic [31:0]      i_pwdata,
    input  wire logic [3:0]       i_pstrb,
    output logic      [31:0]      o_prdata,
    output logic                  o_pready,
    output logic                  o_pslverr,
    input  wire logic             i_exec_boot,
    input  wire logic             i_core_req,
    input  wire fsam_pkg::fsam_op_t i_core_op,
    input  wire logic [15:0]      i_core_addr,
    input  wire logic [7:0]       i_core_wdata,
    output logic                  o_core_ack,
    output logic      [7:0]       o_core_rdata,
    output logic                  o_core_denied,
    output logic                  o_core_hold,
    input  wire logic             i_par_mode
);
    localparam int UPG_W = `FSAM_USER_AW - `FSAM_PAGE_AW;
    localparam fsam_pkg::fsam_state_t ST_RST = '{sec: `FSAM_SEC_RESET,
        wst: fsam_pkg::ST_IDLE, default: '0};

    fsam_pkg::fsam_state_t q;
    fsam_pkg::fsam_state_t d;

    // ----------------------------------------------------------------
    // Nonvolatile arrays
    // ----------------------------------------------------------------
    // user array size
    logic [7:0] user_mem [`FSAM_USER_PAGES * `FSAM_PAGE_BYTES];
    logic [7:0] extra_row_space_mem [`FSAM_PAGE_BYTES];
    logic [7:0] ee_mem   [2**`FSAM_EE_AW];
    logic [7:0] boot_mem [2**`FSAM_BOOT_AW];

    logic                      par;
    logic                      fl_load;
    logic                      ee_load;
    logic                      fl_clear;
    logic                      ee_clear;
    logic [7:0]                fl_data;
    logic [7:0]                ee_data;
    logic                      fl_valid;
    logic                      ee_valid;
    logic                      fl_we;
    logic                      ee_we;
    logic                      f_go;
    logic                      e_go;
    logic                      f_ok;
    logic                      busy;
    logic                      access;
    logic                      wen;
    logic [7:0]                wv;

    // ----------------------------------------------------------------
    // Pin synchroniser and column latches
    // ----------------------------------------------------------------
    fsam_bit_sync u_par_sync
    (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_async   (i_par_mode),
        .o_sync    (par)
    );

    fsam_page_latch u_fl_latch
    (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_load      (fl_load),
        .i_load_idx  (i_core_addr[`FSAM_PAGE_AW-1:0]),
        .i_load_data (i_core_wdata),
        .i_clear     (fl_clear),
        .i_rd_idx    (q.idx),
        .o_rd_data   (fl_data),
        .o_rd_valid  (fl_valid)
    );

    fsam_page_latch u_ee_latch
    (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_load      (ee_load),
        .i_load_idx  (i_core_addr[`FSAM_PAGE_AW-1:0]),
        .i_load_data (i_core_wdata),
        .i_clear     (ee_clear),
        .i_rd_idx    (q.idx),
        .o_rd_data   (ee_data),
        .o_rd_valid  (ee_valid)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Bus decode, core accesses and the write sequencer
    always_comb
    begin
        d        = q;
        d.ack    = 1'b0;
        fl_load  = 1'b0;
        ee_load  = 1'b0;
        fl_clear = 1'b0;
        ee_clear = 1'b0;
        f_go     = 1'b0;
        e_go     = 1'b0;
        f_ok     = 1'b0;
        busy     = (q.wst != fsam_pkg::ST_IDLE);
        access   = i_psel && i_penable;
        wen      = access && !q.apb_done && i_pwrite && i_pstrb[0];
        wv       = i_pwdata[7:0];
        fl_we    = (q.wst == fsam_pkg::ST_COPY) && !q.wr_is_ee && fl_valid;
        ee_we    = (q.wst == fsam_pkg::ST_COPY) && q.wr_is_ee && ee_valid;

        // One wait state: data is registered, pready follows a cycle later
        d.apb_done = access && !q.apb_done;
        if (access && !q.apb_done)
        begin
            d.prdata  = '0;
            d.pslverr = 1'b0;
            case (i_paddr)
                `FSAM_OFS_FMAP:   d.prdata[7:0] = q.fmap;
                `FSAM_OFS_EEMAP:  d.prdata[7:0] = q.eemap;
                `FSAM_OFS_SEC:    d.prdata[7:0] = q.sec;
                `FSAM_OFS_STATUS:
                begin
                    d.prdata[`FSAM_ST_FBUSY]   = busy && !q.wr_is_ee;
                    d.prdata[`FSAM_ST_EBUSY]   = busy && q.wr_is_ee;
                    d.prdata[`FSAM_ST_HOLD]    = q.wr_hold;
                    d.prdata[`FSAM_ST_REFUSED] = q.refused;
                end
                default:          d.pslverr = 1'b1;
            endcase
        end

        // Arm and launch sequences; other values set the mapping and clear the arm
        if (wen && i_paddr == `FSAM_OFS_FMAP)
        begin
            if (wv[7:4] == `FSAM_CMD_ARM)
            begin
                d.f_armed = 1'b1;
                d.f_tgt   = wv[3:0];
            end
            else if (wv[7:4] == `FSAM_CMD_GO && q.f_armed)
            begin
                d.f_armed = 1'b0;
                f_go      = 1'b1;
            end
            else
            begin
                d.fmap    = wv;
                d.f_armed = 1'b0;
            end
        end
        if (wen && i_paddr == `FSAM_OFS_EEMAP)
        begin
            if (wv[7:4] == `FSAM_CMD_ARM)
                d.e_armed = 1'b1;
            else if (wv[7:4] == `FSAM_CMD_GO && q.e_armed)
            begin
                d.e_armed = 1'b0;
                e_go      = 1'b1;
            end
            else
            begin
                d.eemap   = wv;
                d.e_armed = 1'b0;
            end
        end
        if (wen && i_paddr == `FSAM_OFS_STATUS && wv[`FSAM_ST_REFUSED])
            d.refused = 1'b0;

        case (q.f_tgt)
            `FSAM_MAP_NONE: f_ok = i_exec_boot || par;
            `FSAM_MAP_EXTRA_ROW_SPACE: f_ok = 1'b1;
            `FSAM_MAP_SEC:  f_ok = i_exec_boot || par;
            `FSAM_MAP_BOOT: f_ok = par;
            default:        f_ok = 1'b0;
        endcase

        // refusal leaves arrays and execution alone; set beats clear
        if ((f_go && (!f_ok || busy)) || (e_go && busy))
            d.refused = 1'b1;
        else if (f_go || e_go)
        begin
            d.wst      = fsam_pkg::ST_WAIT;
            d.tmr      = PROG_CYCLES - `FSAM_TMR_W'(1);
            d.wr_is_ee = e_go;
            d.wr_tgt   = q.f_tgt;
            d.wr_par   = par;
            // only user code writing flash idles the core
            d.wr_hold  = f_go && !i_exec_boot && !par;
        end

        // Sequencer: program time, then walk the latch byte by byte
        case (q.wst)
            fsam_pkg::ST_IDLE: d.idx = '0;
            fsam_pkg::ST_WAIT:
            begin
                if (q.tmr == '0)
                    d.wst = fsam_pkg::ST_COPY;
                else
                    d.tmr = q.tmr - `FSAM_TMR_W'(1);
            end
            fsam_pkg::ST_COPY:
            begin
                d.idx = q.idx + 1'b1;
                if (q.idx == `FSAM_PAGE_AW'(`FSAM_PAGE_BYTES - 1))
                begin
                    d.wst    = fsam_pkg::ST_IDLE;
                    d.wr_hold = 1'b0;
                    fl_clear = !q.wr_is_ee;
                    ee_clear = q.wr_is_ee;
                end
            end
            default: d.wst = fsam_pkg::ST_IDLE;
        endcase

        // lower nibble kept unless written in parallel mode
        if (fl_we && q.wr_tgt == `FSAM_MAP_SEC && q.idx == '0)
            d.sec = {fl_data[7:4], q.wr_par ? fl_data[3:0] : q.sec[3:0]};

        // Core accesses answer one cycle after the request
        if (i_core_req)
        begin
            d.ack    = 1'b1;
            d.denied = 1'b0;
            d.rdata  = `FSAM_ERASED;
            case (i_core_op)
                fsam_pkg::OP_CODE_RD:
                begin
                    // plain map reads only the user array
                    case (q.fmap[3:0])
                        `FSAM_MAP_NONE: d.rdata = user_mem[i_core_addr[`FSAM_USER_AW-1:0]];
                        `FSAM_MAP_EXTRA_ROW_SPACE:
                        begin
                            if (i_core_addr[15:7] == `FSAM_EXTRA_ROW_SPACE_BASE)
                                d.rdata = extra_row_space_mem[i_core_addr[`FSAM_PAGE_AW-1:0]];
                            else
                                d.denied = 1'b1;
                        end
                        `FSAM_MAP_SEC:
                        begin
                            if (i_core_addr == `FSAM_SEC_ADDR)
                                d.rdata = q.sec;
                            else
                                d.denied = 1'b1;
                        end
                        default: d.denied = 1'b1;
                    endcase
                end
                fsam_pkg::OP_BOOT_RD: d.rdata = boot_mem[i_core_addr[`FSAM_BOOT_AW-1:0]];
                fsam_pkg::OP_DATA_RD:
                begin
                    // EEPROM visible to data reads only while mapped
                    if (q.eemap[`FSAM_EE_MAP_BIT])
                        d.rdata = ee_mem[i_core_addr[`FSAM_EE_AW-1:0]];
                    else
                        d.denied = 1'b1;
                end
                fsam_pkg::OP_DATA_WR:
                begin
                    // latch loads, refused while that latch drains
                    if (q.eemap[`FSAM_EE_MAP_BIT])
                    begin
                        ee_load  = !(busy && q.wr_is_ee);
                        d.denied = busy && q.wr_is_ee;
                        if (ee_load)
                            d.e_page = i_core_addr[`FSAM_EE_AW-1:`FSAM_PAGE_AW];
                    end
                    else
                    begin
                        fl_load  = !(busy && !q.wr_is_ee);
                        d.denied = busy && !q.wr_is_ee;
                        if (fl_load)
                            d.f_page = i_core_addr[`FSAM_USER_AW-1:`FSAM_PAGE_AW];
                    end
                end
                default: d.denied = 1'b1;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            q <= ST_RST;
        else
            q <= d;
    end

    // Array writes, one loaded byte per cycle; arrays hold no reset
    always_ff @(posedge i_ref_clk)
    begin
        if (fl_we && q.wr_tgt == `FSAM_MAP_NONE)
            user_mem[{q.f_page, q.idx}] <= fl_data;
        if (fl_we && q.wr_tgt == `FSAM_MAP_EXTRA_ROW_SPACE)
            extra_row_space_mem[q.idx] <= fl_data;
        if (fl_we && q.wr_tgt == `FSAM_MAP_BOOT)
            boot_mem[{q.f_page[`FSAM_BOOT_AW-`FSAM_PAGE_AW-1:0], q.idx}] <= fl_data;
        if (ee_we)
            ee_mem[{q.e_page, q.idx}] <= ee_data;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_prdata      = q.prdata;
    assign o_pready      = q.apb_done;
    assign o_pslverr     = q.pslverr;
    assign o_core_ack    = q.ack;
    assign o_core_rdata  = q.rdata;
    assign o_core_denied = q.denied;
    assign o_core_hold   = q.wr_hold;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_user_wr_refused: assert property (f_go && q.f_tgt == `FSAM_MAP_NONE && !i_exec_boot
        && !par |=> q.refused && !$rose(o_core_hold)) else $error("user self-write not refused");
    a_boot_wr_par: assert property (fl_we && q.wr_tgt == `FSAM_MAP_BOOT |-> q.wr_par)
        else $error("boot flash written outside parallel mode");
    a_core_ack_next: assert property (i_core_req |=> o_core_ack ##1 (o_core_ack == $past(i_core_req)))
        else $error("core access not answered next cycle");
    a_extra_row_space_window: assert property (i_core_req && i_core_op == fsam_pkg::OP_CODE_RD
        && q.fmap[3:0] == `FSAM_MAP_EXTRA_ROW_SPACE && i_core_addr[15:7] != `FSAM_EXTRA_ROW_SPACE_BASE
        |=> o_core_denied) else $error("extra row answered outside window");
    a_plain_map: assert property (i_core_req && i_core_op == fsam_pkg::OP_CODE_RD
        && q.fmap == 8'h00 |=> !o_core_denied) else $error("plain code read denied");
    a_sec_low_nib: assert property (!q.wr_par |=> $stable(q.sec[3:0]))
        else $error("security lower nibble changed by software");
    // EEPROM write never idles the core
    a_ee_rww: assert property (q.wr_is_ee && q.wst != fsam_pkg::ST_IDLE |-> !o_core_hold)
        else $error("EEPROM write stalled the core");
    a_ee_launch: assert property (e_go && !busy |=> q.wst == fsam_pkg::ST_WAIT
        && q.wr_is_ee && !$rose(q.refused) [*1]) else $error("EEPROM launch not started");
    a_ee_mapped: assert property (i_core_req && i_core_op == fsam_pkg::OP_DATA_RD
        && q.eemap[`FSAM_EE_MAP_BIT] |=> !o_core_denied) else $error("mapped EEPROM denied");
endmodule // fsam_top
`default_nettype wire

/* File: tb/fsam_core_mdl.sv */
// Processor core model issuing one-cycle accesses
`default_nettype none
module fsam_core_mdl
(
    input  wire logic          i_ref_clk,
    input  wire logic          i_ack,
    input  wire logic [7:0]    i_rdata,
    input  wire logic          i_denied,
    output logic               o_req,
    output fsam_pkg::fsam_op_t o_op,
    output logic [15:0]        o_addr,
    output logic [7:0]         o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial
    begin
        o_req = 1'b0;
        o_op = fsam_pkg::OP_CODE_RD;
        o_addr = 16'h0;
        o_wdata = 8'h0;
    end
    // One access; released lines flip so stale values never match
    task automatic acc(input fsam_pkg::fsam_op_t p, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] r, output logic dn);
        o_req <= 1'b1;
        o_op <= p;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_ref_clk);
        o_req <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
        @(posedge i_ref_clk);
        r = (i_ack === 1'b1) ? i_rdata : 8'hx;
        dn = i_denied;
    endtask
endmodule // fsam_core_mdl
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the flash space access mapper
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk, rst_n, psel, pen, pwr, pready, perr, boot, par;
    logic               req, ack, den, hold, e, dn, hs;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic [3:0]         pstrb;
    logic [15:0]        caddr;
    logic [7:0]         cwd, crd, rb, v;
    fsam_pkg::fsam_op_t op;
    int                 fails, checks, seed, sec, mem[int];
    // Short program time keeps page writes brief
    fsam_top #(.PROG_CYCLES(16'h0004)) DUT
    (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
        .i_exec_boot(boot), .i_core_req(req), .i_core_op(op),
        .i_core_addr(caddr), .i_core_wdata(cwd), .o_core_ack(ack),
        .o_core_rdata(crd), .o_core_denied(den), .o_core_hold(hold),
        .i_par_mode(par)
    );
    fsam_core_mdl CORE
    (
        .i_ref_clk(clk), .i_ack(ack), .i_rdata(crd), .i_denied(den),
        .o_req(req), .o_op(op), .o_addr(caddr), .o_wdata(cwd)
    );
    // Clock source
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // APB transfer; waits on pready, failing after 9 cycles without it
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 9);
        rd = prdata;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1)
        begin
            fails++;
            close_out();
        end
        @(posedge clk);
    endtask
    // Poll status until both writers idle, noting any hold
    task automatic idle();
        hs = 1'b0;
        for (int n = 0; n < 99; n++)
        begin
            apb(1'b0, 12'h008, 32'h0);
            hs |= rd[2];
            if (rd[1:0] == 2'b00) return;
        end
        fails++;
        close_out();
    endtask
    // Load random latch bytes, launch, wait; reg 004h for EEPROM (sp 9)
    task automatic prog(input int sp, input logic [15:0] b, input int n, input bit ok);
        logic [11:0] r;
        r = (sp == 9) ? 12'h004 : 12'h000;
        for (int i = 0; i < n; i++)
        begin
            v = 8'($random(seed));
            CORE.acc(fsam_pkg::OP_DATA_WR, b + 16'(i), v, rb, dn);
            chk(dn, 0);
            if (ok) mem[sp * 65536 + int'(b) + i] = v;
        end
        apb(1'b1, r, 32'h50 | sp);
        apb(1'b1, r, 32'hA0 | sp);
        idle();
        chk(hold, 0);
    endtask
    task automatic rdback(input int sp, input logic [15:0] b, input int n);
        for (int i = 0; i < n; i++)
        begin
            CORE.acc(sp == 9 ? fsam_pkg::OP_DATA_RD : fsam_pkg::OP_CODE_RD,
                     b + 16'(i), 8'h0, rb, dn);
            chk(rb, mem[sp * 65536 + int'(b) + i]);
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        {rst_n, psel, pen, pwr, boot, par} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        seed = 32'haf72;
        sec = 8'hFF;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, 12'h000, 32'h0); chk(rd, 0);
        apb(1'b0, 12'h00C, 32'h0); chk(rd, sec);
        apb(1'b0, 12'h010, 32'h0); chk(e, 1);
        $display("test reset done");
        boot <= 1'b1;
        prog(0, 16'h0000, 4, 1); chk(hs, 0);
        rdback(0, 16'h0000, 4);
        boot <= 1'b0;
        prog(0, 16'h0000, 4, 0); chk(rd[3], 1);
        rdback(0, 16'h0000, 4);
        apb(1'b1, 12'h008, 32'h8);
        apb(1'b1, 12'h000, 32'h58);
        apb(1'b1, 12'h000, 32'hA8);
        apb(1'b0, 12'h008, 32'h0); chk(rd[3], 1);
        apb(1'b1, 12'h008, 32'h8);
        $display("test user flash done");
        prog(2, 16'hFF80, 4, 1); chk(hs, 1);
        apb(1'b1, 12'h000, 32'h2);
        rdback(2, 16'hFF80, 4);
        CORE.acc(fsam_pkg::OP_CODE_RD, 16'h0010, 8'h0, rb, dn); chk(dn, 1);
        apb(1'b1, 12'h000, 32'h0);
        rdback(0, 16'h0000, 1);
        $display("test extra row done");
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, 12'h000, 32'h4);
            CORE.acc(fsam_pkg::OP_CODE_RD, 16'h0000, 8'h0, rb, dn); chk(rb, sec);
            CORE.acc(fsam_pkg::OP_CODE_RD, 16'h0001, 8'h0, rb, dn); chk(dn, 1);
            apb(1'b1, 12'h000, 32'h0);
            boot <= 1'b1;
            par <= k[0];
            repeat (3) @(posedge clk);
            prog(4, 16'h0000, 1, 0);
            sec = k ? v : {v[7:4], sec[3:0]};
            apb(1'b0, 12'h00C, 32'h0); chk(rd, sec);
        end
        prog(8, 16'h0000, 1, 1);
        CORE.acc(fsam_pkg::OP_BOOT_RD, 16'h0000, 8'h0, rb, dn);
        chk(rb, mem[8 * 65536]);
        {boot, par} <= 2'b00;
        $display("test security done");
        CORE.acc(fsam_pkg::OP_DATA_RD, 16'h0100, 8'h0, rb, dn); chk(dn, 1);
        apb(1'b1, 12'h004, 32'h2);
        prog(9, 16'h0100, 3, 1); chk(hs, 0);
        rdback(9, 16'h0100, 3);
        apb(1'b1, 12'h004, 32'h0);
        $display("test eeprom done");
        close_out();
    end
endmodule // tb
`default_nettype wire
